// File: include/wdw_pkg.sv
// package for the watchdog and wake-up block: register map, fields, reset values, timing
// assumes a 20 MHz system clock and an Avalon-MM register bus with 32-bit data
package wdw_pkg;
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned SLOW_OSC_HZ = 32000;
	localparam int unsigned SOFT_RESET_DELAY_US = 16;
	localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_DELAY_US * (CLK_HZ / 1000000) > 0) ?
		SOFT_RESET_DELAY_US * (CLK_HZ / 1000000) : 1;
	localparam int unsigned RESET_PULSE_CYCLES = 4;

	// byte offsets, 32-bit aligned words
	localparam logic [3:0] OFS_WDT_CTRL = 4'h0;
	localparam logic [3:0] OFS_RST_CAUSE = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_IRQ_STAT = 4'hc;

	// watchdog_control layout and values
	localparam int unsigned KEY_POS = 3;
	localparam int unsigned SEL_POS = 0;
	localparam logic [4:0] KEY_DISABLE = 5'h15;
	localparam logic [4:0] KEY_ENABLE = 5'h0a;
	localparam logic [2:0] SEL_RESET = 3'h3;
	localparam logic [7:0] WDT_CTRL_RESET = {KEY_ENABLE, SEL_RESET};

	// reset_cause_flags bit positions
	localparam int unsigned WRF_POS = 0;
	localparam int unsigned LRF_POS = 1;
	localparam int unsigned LOW_VOLTAGE_RESET_FLAG_POS = 2;
	localparam int unsigned RESET_CTRL_SW_FLAG_POS = 3;

	// status register bit positions
	localparam int unsigned PDF_POS = 0;
	localparam int unsigned TO_POS = 1;
	localparam int unsigned HALTED_POS = 2;

	// interrupt status/mask bits
	localparam int unsigned EV_WAKE = 0;
	localparam int unsigned EV_EXPIRE = 1;
	localparam int unsigned EV_KEYRST = 2;
	localparam int unsigned EV_NUM = 3;

	localparam int unsigned CNT_W = 19;

	typedef enum logic [1:0] {
		WDW_RUN,
		WDW_HALT,
		WDW_KEYWAIT
	} wdw_mode_t;

	typedef struct packed {
		logic [7:0] wdt_ctrl;
		logic [7:0] rst_cause;
		logic power_down_flag;
		logic watchdog_expiry_flag;
		logic [CNT_W-1:0] count;
		logic [7:0] porta_wake_mask;
		logic [7:0] porta_s1;
		logic [7:0] porta_s2;
		logic [7:0] porta_prev;
		logic osc_s1;
		logic osc_s2;
		logic osc_prev;
		logic [31:0] delay;
		logic [2:0] rst_pulse;
		logic [31:0] pend_at_halt;
		logic wake_p;
		logic vector_p;
		logic pcsp_rst_p;
		logic [EV_NUM-1:0] irq_stat;
		logic [EV_NUM-1:0] irq_mask;
		logic [31:0] rdata;
		logic rvalid;
		wdw_mode_t mode;
	} wdw_state_t;

	typedef struct packed {
		logic halt;
		logic watchdog_clear_instruction;
		logic fast_idle_enable;
		logic slow_idle_enable;
		logic [31:0] irq_pend;
		logic [31:0] irq_en;
		logic stack_full;
	} wdw_core_t;
endpackage : wdw_pkg

// File: hw/wdw_top.sv
// watchdog timer with keyed enable, reset-cause flags and halt/wake-up control
// assumes the core pulses halt and watchdog_clear_instruction for one cycle and acts on the wake and reset pulses
`timescale 1ns/1ns
module wdw_top (
	input wire logic clk_i, // 20 MHz system clock
	input wire logic sys_rst_i, // asynchronous power-on reset, active high
	input wire logic [3:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	input wire wdw_pkg::wdw_core_t core_i, // core request group
	input wire logic slow_internal_osc_i, // slow oscillator, async
	input wire logic [7:0] porta_i, // port a pins, async
	output logic halted_o, // core halted in sleep/idle
	output logic sleep_o, // all clocks but watchdog's off
	output logic wake_o, // wake pulse, resume after halt
	output logic vector_o, // take interrupt on wake
	output logic pcsp_rst_o, // reset only pc and stack pointer
	output logic dev_rst_o, // full device reset pulse
	output logic irq_o // level interrupt
);
	wdw_pkg::wdw_state_t s_q;
	wdw_pkg::wdw_state_t s_d;

	function automatic logic [wdw_pkg::CNT_W-1:0] limit_of(input logic [2:0] sel);
		case (sel)
			3'h0: limit_of = wdw_pkg::CNT_W'(1) << 8;
			3'h1: limit_of = wdw_pkg::CNT_W'(1) << 10;
			3'h2: limit_of = wdw_pkg::CNT_W'(1) << 12;
			3'h3: limit_of = wdw_pkg::CNT_W'(1) << 14;
			default: limit_of = wdw_pkg::CNT_W'(1) << (5'd15 + {2'h0, sel[1:0]});
		endcase
	endfunction : limit_of

	function automatic logic key_bad(input logic [4:0] key);
		key_bad = (key != wdw_pkg::KEY_ENABLE) && (key != wdw_pkg::KEY_DISABLE);
	endfunction : key_bad

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
			input logic be);
		merge8 = be ? wd[7:0] : old;
	endfunction : merge8

	////////////////////////////////////////////////////////////////////////////////
	localparam int unsigned EV_NUM_W = wdw_pkg::EV_NUM;
	logic access;
	logic commit;
	logic wr_ctrl;
	logic wr_cause;
	logic wr_stat;
	logic wr_irq;
	logic slow_tick;
	logic overflow;
	logic [7:0] pin_fall;
	logic [31:0] new_irq;
	logic wdt_on;
	logic [EV_NUM_W-1:0] ev;
	logic [7:0] ctrl_new;

	always_comb begin
		s_d = s_q;
		ev = '0;
		access = (avs_read_i || avs_write_i) && !s_q.rvalid;
		// a write lands only at the edge that sees waitrequest low, never while stalled
		commit = avs_write_i && s_q.rvalid;
		wr_ctrl = commit && avs_address_i == wdw_pkg::OFS_WDT_CTRL;
		wr_cause = commit && avs_address_i == wdw_pkg::OFS_RST_CAUSE;
		wr_stat = commit && avs_address_i == wdw_pkg::OFS_STATUS;
		wr_irq = commit && avs_address_i == wdw_pkg::OFS_IRQ_STAT;
		ctrl_new = merge8(s_q.wdt_ctrl, avs_writedata_i, avs_byteenable_i[0]);

		// synchronisers: logic reads only the second stage and the delayed copy after it, never the first
		s_d.osc_s1 = slow_internal_osc_i;
		s_d.osc_s2 = s_q.osc_s1;
		s_d.osc_prev = s_q.osc_s2;
		s_d.porta_s1 = porta_i;
		s_d.porta_s2 = s_q.porta_s1;
		s_d.porta_prev = s_q.porta_s2;
		slow_tick = s_q.osc_s2 && !s_q.osc_prev;
		pin_fall = s_q.porta_prev & ~s_q.porta_s2 & s_q.porta_wake_mask;
		new_irq = core_i.irq_pend & ~s_q.pend_at_halt;

		wdt_on = s_q.wdt_ctrl[wdw_pkg::KEY_POS +: 5] == wdw_pkg::KEY_ENABLE;
		overflow = wdt_on && slow_tick &&
			(s_q.count + 1'b1) >= limit_of(s_q.wdt_ctrl[2:0]);

		s_d.wake_p = 1'b0;
		s_d.vector_p = 1'b0;
		s_d.pcsp_rst_p = 1'b0;
		s_d.rst_pulse = (s_q.rst_pulse != 3'h0) ? s_q.rst_pulse - 3'h1 : 3'h0;

		// watchdog counter
		if (wdt_on && slow_tick) begin
			s_d.count = overflow ? '0 : s_q.count + 1'b1;
		end

		case (s_q.mode)
			wdw_pkg::WDW_RUN: begin
				if (core_i.halt) begin
					s_d.mode = wdw_pkg::WDW_HALT;
					s_d.power_down_flag = 1'b1;
					s_d.watchdog_expiry_flag = 1'b0;
					s_d.count = '0;
					s_d.pend_at_halt = core_i.irq_pend;
				end else if (overflow) begin
					s_d.watchdog_expiry_flag = 1'b1;
					s_d.rst_pulse = 3'(wdw_pkg::RESET_PULSE_CYCLES);
					ev[wdw_pkg::EV_EXPIRE] = 1'b1;
				end
			end
			wdw_pkg::WDW_HALT: begin
				if (overflow) begin
					s_d.watchdog_expiry_flag = 1'b1;
					s_d.pcsp_rst_p = 1'b1;
					s_d.wake_p = 1'b1;
					s_d.mode = wdw_pkg::WDW_RUN;
					ev[wdw_pkg::EV_EXPIRE] = 1'b1;
					ev[wdw_pkg::EV_WAKE] = 1'b1;
				end else if (|new_irq) begin
					s_d.wake_p = 1'b1;
					s_d.vector_p = |(new_irq & core_i.irq_en) && !core_i.stack_full;
					s_d.mode = wdw_pkg::WDW_RUN;
					ev[wdw_pkg::EV_WAKE] = 1'b1;
				end else if (|pin_fall) begin
					s_d.wake_p = 1'b1;
					s_d.mode = wdw_pkg::WDW_RUN;
					ev[wdw_pkg::EV_WAKE] = 1'b1;
				end
			end
			wdw_pkg::WDW_KEYWAIT: begin
				if (s_q.delay <= 32'h1) begin
					s_d.rst_pulse = 3'(wdw_pkg::RESET_PULSE_CYCLES);
					s_d.wdt_ctrl = wdw_pkg::WDT_CTRL_RESET;
					s_d.mode = wdw_pkg::WDW_RUN;
				end else begin
					s_d.delay = s_q.delay - 32'h1;
				end
			end
			default: s_d.mode = wdw_pkg::WDW_RUN;
		endcase

		if (core_i.watchdog_clear_instruction) begin
			s_d.count = '0;
			s_d.power_down_flag = 1'b0;
		end

		// register writes
		if (wr_ctrl) begin
			s_d.wdt_ctrl = ctrl_new;
			if (key_bad(ctrl_new[wdw_pkg::KEY_POS +: 5])) begin
				s_d.count = '0;
				s_d.mode = wdw_pkg::WDW_KEYWAIT;
				s_d.delay = wdw_pkg::SOFT_RESET_CYCLES;
				s_d.rst_cause[wdw_pkg::WRF_POS] = 1'b1;
				ev[wdw_pkg::EV_KEYRST] = 1'b1;
			end
		end
		if (wr_cause && avs_byteenable_i[0]) begin
			// only software clears; a set in the same cycle wins
			s_d.rst_cause[3:0] = avs_writedata_i[3:0] &
				(s_q.rst_cause[3:0] | s_d.rst_cause[3:0]);
			if (ev[wdw_pkg::EV_KEYRST]) begin
				s_d.rst_cause[wdw_pkg::WRF_POS] = 1'b1;
			end
		end
		if (wr_stat && avs_byteenable_i[1]) begin
			s_d.porta_wake_mask = avs_writedata_i[15:8];
		end
		if (wr_irq) begin
			if (avs_byteenable_i[0]) begin
				s_d.irq_stat = s_q.irq_stat & ~avs_writedata_i[EV_NUM_W-1:0];
			end
			if (avs_byteenable_i[1]) begin
				s_d.irq_mask = avs_writedata_i[8 +: EV_NUM_W];
			end
		end
		s_d.irq_stat = s_d.irq_stat | ev;

		// read answer, one cycle after the request
		s_d.rvalid = access;
		if (access && avs_read_i) begin
			case (avs_address_i)
				wdw_pkg::OFS_WDT_CTRL: s_d.rdata = {24'h0, s_q.wdt_ctrl};
				wdw_pkg::OFS_RST_CAUSE: s_d.rdata = {28'h0, s_q.rst_cause[3:0]};
				wdw_pkg::OFS_STATUS: s_d.rdata = {16'h0, s_q.porta_wake_mask, 5'h0,
					s_q.mode == wdw_pkg::WDW_HALT, s_q.watchdog_expiry_flag,
					s_q.power_down_flag};
				wdw_pkg::OFS_IRQ_STAT: s_d.rdata = {21'h0, s_q.irq_mask, 5'h0, s_q.irq_stat};
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.wdt_ctrl <= wdw_pkg::WDT_CTRL_RESET;
			s_q.mode <= wdw_pkg::WDW_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.rvalid;
	assign avs_readdata_o = s_q.rdata;
	assign halted_o = s_q.mode == wdw_pkg::WDW_HALT;
	// sleep keeps only the watchdog's clock; idle modes leave the others to the clock unit
	assign sleep_o = halted_o && !core_i.fast_idle_enable && !core_i.slow_idle_enable;
	assign wake_o = s_q.wake_p;
	assign vector_o = s_q.vector_p;
	assign pcsp_rst_o = s_q.pcsp_rst_p;
	assign dev_rst_o = s_q.rst_pulse != 3'h0;
	assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
endmodule : wdw_top

// File: verif/wdw_top_sva.sv
// port-level timing checks for the watchdog and wake-up block
// assumes one clock domain and the asynchronous high reset
`timescale 1ns/1ns
module wdw_top_sva (
	input wire logic clk_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic avs_read_i, // read
	input wire logic avs_write_i, // write
	input wire logic avs_waitrequest_o, // stall
	input wire wdw_pkg::wdw_core_t core_i, // core group
	input wire logic halted_o, // halted
	input wire logic sleep_o, // sleep
	input wire logic wake_o, // wake pulse
	input wire logic vector_o, // vector pulse
	input wire logic pcsp_rst_o, // pc/sp reset
	input wire logic dev_rst_o // device reset
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_read_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("read answer not one cycle late");
	chk_write_wait: assert property ($rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("write answer not one cycle late");
	chk_halt_enter: assert property (core_i.halt && !halted_o && !dev_rst_o |=> halted_o)
		else $error("halt not entered");
	chk_sleep_mode: assert property (sleep_o == (halted_o && !core_i.fast_idle_enable && !core_i.slow_idle_enable))
		else $error("sleep level wrong");
	chk_wake_halted: assert property (wake_o |-> $past(halted_o))
		else $error("wake while running");
	chk_wake_resume: assert property (wake_o |=> !halted_o)
		else $error("still halted after wake");
	chk_vector_room: assert property (vector_o |-> wake_o && !core_i.stack_full)
		else $error("vector without wake or room");
	chk_pcsp_only: assert property (pcsp_rst_o |-> wake_o && !dev_rst_o)
		else $error("pc/sp reset outside wake");
	chk_rst_pulse: assert property ($rose(dev_rst_o) |-> dev_rst_o[*4] ##1 !dev_rst_o)
		else $error("device reset pulse length wrong");
endmodule : wdw_top_sva
bind wdw_top wdw_top_sva u_sva (.clk_i, .sys_rst_i, .avs_read_i, .avs_write_i,
	.avs_waitrequest_o, .core_i, .halted_o, .sleep_o, .wake_o, .vector_o, .pcsp_rst_o, .dev_rst_o);

// File: verif/watchdog_and_wakeup_test.sv
// self-checking bench for the watchdog and wake-up block
// assumes the bench plays core, pins and a fast slow oscillator
`timescale 1ns/1ns
module watchdog_and_wakeup_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic wait_o, halted, sleep, wake, vec, pcsp, drst, irq;
	wdw_pkg::wdw_core_t core = '0;
	logic osc = 1'b0;
	logic [7:0] pa = 8'hff;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int t;
	logic [31:0] v;
	always #25 clk_i = ~clk_i;
	// one slow tick every 8 clocks keeps a 2^8 time-out at 2048 cycles
	always begin
		repeat (4) @(posedge clk_i);
		osc <= ~osc;
	end
	wdw_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o), .core_i(core), .slow_internal_osc_i(osc), .porta_i(pa),
		.halted_o(halted), .sleep_o(sleep), .wake_o(wake), .vector_o(vec), .pcsp_rst_o(pcsp),
		.dev_rst_o(drst), .irq_o(irq));
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do @(posedge clk_i); while (wait_o !== 1'b0);
		v = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic tick(input logic h);
		@(posedge clk_i);
		core.halt <= h;
		core.watchdog_clear_instruction <= !h;
		@(posedge clk_i);
		core.halt <= 1'b0;
		core.watchdog_clear_instruction <= 1'b0;
	endtask : tick
	task automatic wait_for(input int n, input logic dr);
		for (t = 0; t < n; t++) begin
			@(negedge clk_i);
			if ((dr ? drst : wake) === 1'b1)
				break;
		end
	endtask : wait_for
	task automatic irq_wake(input logic [31:0] p, input logic full, input logic ev);
		core.irq_pend <= 32'h0;
		core.stack_full <= full;
		tick(1'b1);
		core.irq_pend <= p;
		wait_for(20, 1'b0);
		chk(t < 20, 1'b1);
		chk(vec, ev);
	endtask : irq_wake
	task automatic t_regs();
		bus(1'b0, 4'h0, 32'h0);
		chk(v, 32'h53);
		bus(1'b0, 4'h4, 32'h0);
		chk(v, 32'h0);
		bus(1'b0, 4'h1, 32'h0);
		chk(v, 32'h0);
		$display("done regs");
	endtask : t_regs
	task automatic t_count();
		bus(1'b1, 4'h0, 32'h50);
		repeat (3) begin
			tick(1'b0);
			wait_for(1500, 1'b1);
			chk(t, 1500);
		end
		tick(1'b0);
		wait_for(2200, 1'b1);
		chk(t >= 2020 && t <= 2075, 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk(v[1], 1'b1);
		$display("done count");
	endtask : t_count
	task automatic t_key();
		bus(1'b1, 4'h0, 32'ha8);
		wait_for(2500, 1'b1);
		chk(t, 2500);
		bus(1'b1, 4'h0, 32'h0);
		wait_for(400, 1'b1);
		chk(t >= 316 && t <= 324, 1'b1);
		bus(1'b0, 4'h4, 32'h0);
		chk(v[0], 1'b1);
		bus(1'b1, 4'h4, 32'h1);
		bus(1'b0, 4'h4, 32'h0);
		chk(v[0], 1'b1);
		bus(1'b1, 4'h4, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk(v[0], 1'b0);
		$display("done key");
	endtask : t_key
	task automatic t_halt();
		bus(1'b1, 4'h0, 32'h53);
		bus(1'b1, 4'h8, 32'h0800);
		bus(1'b1, 4'hc, 32'h0100);
		core.irq_pend <= 32'h4;
		tick(1'b1);
		@(negedge clk_i);
		chk({halted, sleep}, 2'b11);
		bus(1'b0, 4'h8, 32'h0);
		chk(v[1:0], 2'b01);
		pa <= 8'hfe;
		wait_for(20, 1'b0);
		chk(t, 20);
		pa <= 8'hf6;
		wait_for(20, 1'b0);
		chk({t < 20, vec, pcsp}, 3'b100);
		@(negedge clk_i);
		chk(irq, 1'b1);
		bus(1'b1, 4'hc, 32'h0);
		@(negedge clk_i);
		chk(irq, 1'b0);
		bus(1'b1, 4'hc, 32'h0107);
		@(negedge clk_i);
		chk(irq, 1'b0);
		pa <= 8'hff;
		core.irq_en <= 32'h20;
		irq_wake(32'h20, 1'b0, 1'b1);
		irq_wake(32'h40, 1'b0, 1'b0);
		irq_wake(32'h20, 1'b1, 1'b0);
		$display("done halt");
	endtask : t_halt
	task automatic t_wdt_halt();
		core.irq_pend <= 32'h0;
		bus(1'b1, 4'h0, 32'h50);
		core.fast_idle_enable <= 1'b1;
		tick(1'b1);
		@(negedge clk_i);
		chk({halted, sleep}, 2'b10);
		wait_for(2200, 1'b0);
		chk({t < 2200, pcsp, drst}, 3'b110);
		bus(1'b0, 4'h8, 32'h0);
		chk(v[1:0], 2'b11);
		tick(1'b0);
		bus(1'b0, 4'h8, 32'h0);
		chk(v[0], 1'b0);
		$display("done wdt halt");
	endtask : t_wdt_halt
	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_count();
		t_key();
		t_halt();
		t_wdt_halt();
		finish_test();
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			finish_test();
		end
	end
endmodule : watchdog_and_wakeup_test
